// file: src/ddc_output_ports.sv
/*
  output side of a dual channel downconverter: serial port, parallel word port,
  gain amplifier codes and strobes, daisy chain capture, debug remap, power down.
  assumes samples, word bank, debug word and gain updates come from logic on clk_sys;
  pins from outside are synchronised here.
*/
`timescale 1ns/1ps
module ddc_output_ports (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire logic [ddc_out_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ddc_out_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ddc_out_pkg::DATA_W-1:0] reg_rdata,
  // internal data sources
  input wire logic sample_valid,
  input wire ddc_out_pkg::sample_pair_s sample_a,
  input wire ddc_out_pkg::sample_pair_s sample_b,
  input wire ddc_out_pkg::word_bank_t word_bank,
  input wire logic [ddc_out_pkg::DEBUG_W-1:0] debug_word,
  input wire logic [ddc_out_pkg::GAIN_W-1:0] loop_gain_a,
  input wire logic [ddc_out_pkg::GAIN_W-1:0] loop_gain_b,
  input wire logic gain_update_a,
  input wire logic gain_update_b,
  // input pins
  input wire logic master_reset_n,
  input wire logic converter_power_down,
  input wire logic [ddc_out_pkg::SEL_W-1:0] parallel_word_select,
  input wire logic parallel_port_enable_n,
  input wire logic slave_clock_in,
  // serial pins
  output ddc_out_pkg::serial_pins_s serial_out,
  output logic serial_oe,
  // parallel pins
  output logic [ddc_out_pkg::WORD_W-1:0] parallel_word_bus,
  output logic parallel_oe,
  // gain amplifier pins
  output logic [ddc_out_pkg::GAIN_W-1:0] gain_code_a,
  output logic [ddc_out_pkg::GAIN_W-1:0] gain_code_b,
  output logic gain_latch_a_n,
  output logic gain_latch_b_n,
  // converter control
  output logic adc_power_down
);
  import ddc_out_pkg::*;

  logic [6:0] pin_meta_reg;
  logic [6:0] pin_sync_reg;
  logic mr_n_s;
  logic pd_s;
  logic en_n_s;
  logic sck_in_s;
  logic [SEL_W-1:0] sel_s;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [RATE_W-1:0] rate_reg;
  logic [RATE_W-1:0] div_reg;
  logic phase_reg;
  logic half_tick;
  logic launch;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [PAIR_W-1:0] hold_a_reg;
  logic [PAIR_W-1:0] hold_b_reg;
  logic [PAIR_W-1:0] shift_a_reg;
  logic [PAIR_W-1:0] shift_b_reg;
  logic data_a_reg;
  logic data_b_reg;
  logic frame_reg;
  logic sck_prev_reg;
  logic slave_edge;
  logic [CNT_W-1:0] slave_cnt_reg;
  logic [PAIR_W-1:0] slave_sh_a_reg;
  logic [PAIR_W-1:0] slave_sh_b_reg;
  logic [PAIR_W-1:0] slave_a_reg;
  logic [PAIR_W-1:0] slave_b_reg;
  logic [15:0] slave_words_reg;
  logic [GAIN_W-1:0] gain_code_reg [2];
  logic [GCNT_W-1:0] gain_cnt_reg [2];
  logic gain_latch_reg [2];
  logic [GAIN_W-1:0] gain_in [2];
  logic gain_upd [2];
  logic debug_on;
  logic daisy_on;

  // two flip-flop synchronisers for all pins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta_reg <= 7'h50;
      pin_sync_reg <= 7'h50;
    end
    else
    begin
      pin_meta_reg <= {master_reset_n, converter_power_down, parallel_port_enable_n,
                       slave_clock_in, parallel_word_select};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  assign mr_n_s = pin_sync_reg[6];
  assign pd_s = pin_sync_reg[5];
  assign en_n_s = pin_sync_reg[4];
  assign sck_in_s = pin_sync_reg[3];
  assign sel_s = pin_sync_reg[2:0];
  assign debug_on = ctrl_reg[CTRL_DEBUG];
  assign daisy_on = ctrl_reg[CTRL_DAISY];

  // register writes
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_reg <= CTRL_RESET;
      rate_reg <= RATE_RESET;
    end
    else if (!mr_n_s)
    begin
      ctrl_reg <= CTRL_RESET;
      rate_reg <= RATE_RESET;
    end
    else if (reg_wr && reg_addr == ADDR_CTRL)
      ctrl_reg <= reg_wdata[CTRL_W-1:0];
    else if (reg_wr && reg_addr == ADDR_RATE)
      rate_reg <= reg_wdata[RATE_W-1:0];
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_CTRL: reg_rdata <= DATA_W'(ctrl_reg);
        ADDR_RATE: reg_rdata <= DATA_W'(rate_reg);
        ADDR_STATUS: reg_rdata <= {slave_words_reg, 3'h0, bit_cnt_reg, 7'h00, phase_reg};
        ADDR_SLAVE_A: reg_rdata <= slave_a_reg;
        ADDR_SLAVE_B: reg_rdata <= slave_b_reg;
        default: reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // bit clock divider: half period of rate+1 system cycles
  assign half_tick = (div_reg >= rate_reg);
  assign launch = half_tick && (phase_reg == ctrl_reg[CTRL_CLK_POL]);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      div_reg <= '0;
      phase_reg <= 1'b0;
    end
    else if (!mr_n_s)
    begin
      div_reg <= '0;
      phase_reg <= 1'b0;
    end
    else if (half_tick)
    begin
      div_reg <= '0;
      phase_reg <= ~phase_reg;
    end
    else
      div_reg <= div_reg + 1'b1;
  end

  // sample holding, taken at the next pair start
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_a_reg <= '0;
      hold_b_reg <= '0;
    end
    else if (!mr_n_s)
    begin
      hold_a_reg <= '0;
      hold_b_reg <= '0;
    end
    else if (sample_valid)
    begin
      hold_a_reg <= sample_a;
      hold_b_reg <= sample_b;
    end
  end

  // serial shifter: i word then q word, msb first
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_cnt_reg <= CNT_FIRST;
      shift_a_reg <= '0;
      shift_b_reg <= '0;
      data_a_reg <= 1'b0;
      data_b_reg <= 1'b0;
      frame_reg <= 1'b0;
    end
    else if (!mr_n_s)
    begin
      bit_cnt_reg <= CNT_FIRST;
      shift_a_reg <= '0;
      shift_b_reg <= '0;
      data_a_reg <= 1'b0;
      data_b_reg <= 1'b0;
      frame_reg <= 1'b0;
    end
    else if (launch)
    begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg == CNT_FIRST)
      begin
        data_a_reg <= hold_a_reg[PAIR_W-1];
        data_b_reg <= hold_b_reg[PAIR_W-1];
        shift_a_reg <= {hold_a_reg[PAIR_W-2:0], 1'b0};
        shift_b_reg <= {hold_b_reg[PAIR_W-2:0], 1'b0};
      end
      else
      begin
        data_a_reg <= shift_a_reg[PAIR_W-1];
        data_b_reg <= shift_b_reg[PAIR_W-1];
        shift_a_reg <= {shift_a_reg[PAIR_W-2:0], 1'b0};
        shift_b_reg <= {shift_b_reg[PAIR_W-2:0], 1'b0};
      end
      // one bit period wide, with the first bit of a word or pair
      frame_reg <= ((bit_cnt_reg == CNT_FIRST) || (!ctrl_reg[CTRL_PACKED]
                    && bit_cnt_reg == CNT_SECOND_WORD)) ^ ctrl_reg[CTRL_FRAME_POL];
    end
  end

  // pin stage with debug remap and output enables
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_out <= '0;
      serial_oe <= 1'b0;
    end
    else if (!mr_n_s)
    begin
      serial_out <= '0;
      serial_oe <= 1'b0;
    end
    else
    begin
      serial_oe <= ctrl_reg[CTRL_SERIAL_EN] || debug_on;
      serial_out.bit_clock <= phase_reg;
      if (debug_on)
      begin
        serial_out.serial_data_a <= debug_word[DBG_A];
        serial_out.serial_data_b <= debug_word[DBG_B];
        serial_out.serial_frame_strobe <= debug_word[DBG_FS];
      end
      else
      begin
        serial_out.serial_data_a <= data_a_reg;
        serial_out.serial_data_b <= data_b_reg;
        serial_out.serial_frame_strobe <= frame_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      parallel_word_bus <= '0;
      parallel_oe <= 1'b0;
    end
    else if (!mr_n_s)
    begin
      parallel_word_bus <= '0;
      parallel_oe <= 1'b0;
    end
    else if (debug_on)
    begin
      parallel_word_bus <= debug_word[DBG_PAR_LSB +: WORD_W];
      parallel_oe <= 1'b1;
    end
    else
    begin
      parallel_word_bus <= daisy_on ? word_bank[0] : word_bank[sel_s];
      parallel_oe <= !en_n_s;
    end
  end

  // daisy chain capture from the slave on the select pins
  assign slave_edge = ctrl_reg[CTRL_SLAVE_POL] ? (sck_in_s && !sck_prev_reg)
                                               : (!sck_in_s && sck_prev_reg);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_prev_reg <= 1'b0;
      slave_cnt_reg <= CNT_FIRST;
      slave_sh_a_reg <= '0;
      slave_sh_b_reg <= '0;
      slave_a_reg <= '0;
      slave_b_reg <= '0;
      slave_words_reg <= '0;
    end
    else if (!mr_n_s)
    begin
      sck_prev_reg <= 1'b0;
      slave_cnt_reg <= CNT_FIRST;
      slave_sh_a_reg <= '0;
      slave_sh_b_reg <= '0;
      slave_a_reg <= '0;
      slave_b_reg <= '0;
      slave_words_reg <= '0;
    end
    else
    begin
      sck_prev_reg <= sck_in_s;
      if (daisy_on && slave_edge)
      begin
        slave_sh_a_reg <= {slave_sh_a_reg[PAIR_W-2:0], sel_s[SLV_A]};
        slave_sh_b_reg <= {slave_sh_b_reg[PAIR_W-2:0], sel_s[SLV_B]};
        if (sel_s[SLV_FS] ^ ctrl_reg[CTRL_FRAME_POL])
          slave_cnt_reg <= CNT_ONE;
        else
          slave_cnt_reg <= slave_cnt_reg + 1'b1;
        if (slave_cnt_reg == CNT_LAST && !(sel_s[SLV_FS] ^ ctrl_reg[CTRL_FRAME_POL]))
        begin
          slave_a_reg <= {slave_sh_a_reg[PAIR_W-2:0], sel_s[SLV_A]};
          slave_b_reg <= {slave_sh_b_reg[PAIR_W-2:0], sel_s[SLV_B]};
          slave_words_reg <= slave_words_reg + 1'b1;
        end
      end
    end
  end

  // gain code and latch strobe per channel
  assign gain_in[0] = loop_gain_a;
  assign gain_in[1] = loop_gain_b;
  assign gain_upd[0] = gain_update_a;
  assign gain_upd[1] = gain_update_b;
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_gain
    always_ff @(posedge clk_sys or negedge nrst)
    begin
      if (!nrst)
      begin
        gain_code_reg[ch] <= '0;
        gain_cnt_reg[ch] <= '0;
        gain_latch_reg[ch] <= 1'b0;
      end
      else if (!mr_n_s)
      begin
        gain_code_reg[ch] <= '0;
        gain_cnt_reg[ch] <= '0;
        gain_latch_reg[ch] <= 1'b0;
      end
      else if (gain_upd[ch])
      begin
        gain_code_reg[ch] <= gain_in[ch];
        gain_cnt_reg[ch] <= GCNT_W'(GAIN_STROBE_CYCLES - 1);
        gain_latch_reg[ch] <= 1'b0;
      end
      else if (gain_cnt_reg[ch] != '0)
        gain_cnt_reg[ch] <= gain_cnt_reg[ch] - 1'b1;
      else
        gain_latch_reg[ch] <= 1'b1;
    end
  end
  assign gain_code_a = gain_code_reg[0];
  assign gain_code_b = gain_code_reg[1];
  assign gain_latch_a_n = gain_latch_reg[0];
  assign gain_latch_b_n = gain_latch_reg[1];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      adc_power_down <= 1'b0;
    else
      adc_power_down <= pd_s;
  end

  property p_serial_hiz;
    @(posedge clk_sys) disable iff (!nrst)
    (!ctrl_reg[CTRL_SERIAL_EN] && !debug_on) |=> !serial_oe;
  endproperty
  a_serial_hiz: assert property (p_serial_hiz) else $error("serial pins driven while off");
  property p_par_hiz;
    @(posedge clk_sys) disable iff (!nrst)
    (en_n_s && !debug_on) |=> !parallel_oe;
  endproperty
  a_par_hiz: assert property (p_par_hiz) else $error("parallel bus driven while disabled");
  property p_par_word;
    @(posedge clk_sys) disable iff (!nrst)
    (mr_n_s && !debug_on && !daisy_on && !en_n_s) |=>
      parallel_oe && parallel_word_bus == $past(word_bank[sel_s]);
  endproperty
  a_par_word: assert property (p_par_word) else $error("wrong parallel word");
  property p_msb_first;
    @(posedge clk_sys) disable iff (!nrst)
    (mr_n_s && launch && bit_cnt_reg == CNT_FIRST) |=> data_a_reg == $past(hold_a_reg[PAIR_W-1]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");
  property p_data_edge;
    @(posedge clk_sys) disable iff (!nrst)
    (mr_n_s && $changed(data_a_reg)) |-> $past(launch);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved off launch edge");
  property p_frame;
    @(posedge clk_sys) disable iff (!nrst)
    (mr_n_s && launch && bit_cnt_reg == CNT_FIRST) |=>
      frame_reg != $past(ctrl_reg[CTRL_FRAME_POL]);
  endproperty
  a_frame: assert property (p_frame) else $error("frame strobe missing at word start");
  property p_debug;
    @(posedge clk_sys) disable iff (!nrst)
    (mr_n_s && debug_on) |=> serial_out.serial_data_a == $past(debug_word[DBG_A])
      && parallel_word_bus == $past(debug_word[DBG_PAR_LSB +: WORD_W]);
  endproperty
  a_debug: assert property (p_debug) else $error("debug remap wrong");
  property p_gain_strobe;
    @(posedge clk_sys) disable iff (!nrst)
    (mr_n_s && gain_update_a) |=> (!gain_latch_a_n && gain_code_a == $past(loop_gain_a));
  endproperty
  a_gain_strobe: assert property (p_gain_strobe) else $error("gain latch not strobed");
  property p_gain_width;
    @(posedge clk_sys) disable iff (!nrst)
    ($rose(gain_latch_b_n)) |-> $past(!gain_latch_b_n, 3);
  endproperty
  a_gain_width: assert property (p_gain_width) else $error("gain strobe too short");
  property p_mr_hold;
    @(posedge clk_sys) disable iff (!nrst)
    !mr_n_s |=> (!gain_latch_a_n && !gain_latch_b_n && ctrl_reg == CTRL_RESET);
  endproperty
  a_mr_hold: assert property (p_mr_hold) else $error("master reset not honoured");
  property p_power_down;
    @(posedge clk_sys) disable iff (!nrst)
    ##1 adc_power_down == $past(pd_s);
  endproperty
  a_power_down: assert property (p_power_down) else $error("power down not followed");
  property p_slave_word;
    @(posedge clk_sys) disable iff (!nrst)
    (mr_n_s && $changed(slave_words_reg)) |-> $past(daisy_on && slave_edge);
  endproperty
  a_slave_word: assert property (p_slave_word) else $error("slave word off edge");
  c_pair_sent: cover property (@(posedge clk_sys) launch && bit_cnt_reg == CNT_LAST);
  c_gain_update: cover property (@(posedge clk_sys) gain_update_b ##1 !gain_latch_b_n);
  c_slave_word: cover property (@(posedge clk_sys) $changed(slave_words_reg));
  c_debug_on: cover property (@(posedge clk_sys) debug_on && parallel_oe);
endmodule : ddc_output_ports

// file: shared/ddc_out_pkg.sv
/*
  constants, register map and carrier types for the downconverter output ports.
  assumes a single 50 MHz system clock and a plain strobe register port.
*/
package ddc_out_pkg;
  localparam int WORD_W = 16;
  localparam int PAIR_W = 32;
  localparam int SEL_W = 3;
  localparam int GAIN_W = 3;
  localparam int DEBUG_W = 20;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_WORDS = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RATE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SLAVE_A = 8'h0C;
  localparam logic [7:0] ADDR_SLAVE_B = 8'h10;
  // control fields
  localparam int CTRL_W = 7;
  localparam int CTRL_SERIAL_EN = 0;
  localparam int CTRL_CLK_POL = 1;
  localparam int CTRL_PACKED = 2;
  localparam int CTRL_FRAME_POL = 3;
  localparam int CTRL_DEBUG = 4;
  localparam int CTRL_DAISY = 5;
  localparam int CTRL_SLAVE_POL = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam int RATE_W = 8;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_FIRST = 5'h00;
  localparam logic [4:0] CNT_SECOND_WORD = 5'h10;
  localparam logic [4:0] CNT_LAST = 5'h1F;
  localparam logic [4:0] CNT_ONE = 5'h01;
  // debug and daisy pin positions
  localparam int DBG_A = 1;
  localparam int DBG_B = 0;
  localparam int DBG_FS = 2;
  localparam int DBG_PAR_LSB = 4;
  localparam int SLV_FS = 2;
  localparam int SLV_B = 1;
  localparam int SLV_A = 0;
  // gain latch pulse width
  localparam int CLK_PERIOD_NS = 20;
  localparam int GAIN_STROBE_NS = 60;
  localparam int GAIN_STROBE_CYCLES = (GAIN_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GCNT_W = 3;
  typedef logic [WORD_W-1:0] word_t;
  typedef word_t [NUM_WORDS-1:0] word_bank_t;
  typedef struct packed {
    logic [WORD_W-1:0] i;
    logic [WORD_W-1:0] q;
  } sample_pair_s;
  typedef struct packed {
    logic serial_data_a;
    logic serial_data_b;
    logic bit_clock;
    logic serial_frame_strobe;
  } serial_pins_s;
endpackage : ddc_out_pkg

// file: verif/ddc_link_partner.sv
/*
  far side of the output ports: a serial receiver that rebuilds i/q pairs from the
  serial pins, and a daisy chain slave that drives the select pins and slave clock.
  assumes the bench drives the polarity settings to match the block's control bits.
*/
`timescale 1ns/1ps
module ddc_link_partner (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // serial pins and settings
  input wire ddc_out_pkg::serial_pins_s serial_out,
  input wire logic serial_oe,
  input wire logic clk_pol,
  input wire logic frame_pol,
  // received pairs
  output logic [ddc_out_pkg::PAIR_W-1:0] rx_a,
  output logic [ddc_out_pkg::PAIR_W-1:0] rx_b,
  output logic [1:0] rx_frames,
  output logic [15:0] rx_count,
  // daisy slave pins
  output logic slave_clock_in,
  output logic [ddc_out_pkg::SEL_W-1:0] slave_pins
);
  import ddc_out_pkg::*;
  logic sclk_q;
  logic [PAIR_W-1:0] sh_a;
  logic [PAIR_W-1:0] sh_b;
  logic [5:0] idx;
  logic [1:0] fcnt;
  logic cap;
  logic fr;
  initial slave_clock_in = 1'b0;
  initial slave_pins = '0;
  // capture on the edge opposite the launch edge
  assign cap = serial_oe && (clk_pol ? (!sclk_q && serial_out.bit_clock)
                                     : (sclk_q && !serial_out.bit_clock));
  assign fr = serial_out.serial_frame_strobe ^ frame_pol;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q <= 1'b0;
      sh_a <= '0;
      sh_b <= '0;
      idx <= 6'h3F;
      fcnt <= 2'h0;
      rx_a <= '0;
      rx_b <= '0;
      rx_frames <= 2'h0;
      rx_count <= 16'h0000;
    end
    else
    begin
      sclk_q <= serial_out.bit_clock;
      if (cap && fr && idx[5])
      begin
        sh_a <= {31'h0, serial_out.serial_data_a};
        sh_b <= {31'h0, serial_out.serial_data_b};
        idx <= 6'h01;
        fcnt <= 2'h1;
      end
      else if (cap && !idx[5])
      begin
        sh_a <= {sh_a[30:0], serial_out.serial_data_a};
        sh_b <= {sh_b[30:0], serial_out.serial_data_b};
        fcnt <= fcnt + 2'(fr);
        idx <= (idx == 6'h1F) ? 6'h20 : idx + 6'h01;
        if (idx == 6'h1F)
        begin
          rx_a <= {sh_a[30:0], serial_out.serial_data_a};
          rx_b <= {sh_b[30:0], serial_out.serial_data_b};
          rx_frames <= fcnt + 2'(fr);
          rx_count <= rx_count + 16'h0001;
        end
      end
    end
  end
  // slave sends one pair, msb first, bits change on its rising clock, 160 ns period
  task automatic send_slave(input logic [PAIR_W-1:0] a, input logic [PAIR_W-1:0] b);
    int k;
    @(posedge clk_sys);
    for (k = 31; k >= 0; k--)
    begin
      slave_pins <= {k == 31, b[k], a[k]};
      slave_clock_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      slave_clock_in <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    slave_pins <= {1'b0, ~b[0], ~a[0]};
  endtask : send_slave
endmodule : ddc_link_partner

// file: verif/ddc_output_ports_test.sv
/*
  self-checking bench for the downconverter output ports.
  assumes the partner model stands on the serial, select and slave clock pins.
*/
`timescale 1ns/1ps
module ddc_output_ports_test;
  import ddc_out_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic sample_valid = 1'b0;
  sample_pair_s sample_a = '0;
  sample_pair_s sample_b = '0;
  word_bank_t word_bank = '0;
  logic [DEBUG_W-1:0] debug_word = '0;
  logic [GAIN_W-1:0] loop_gain_a = '0;
  logic [GAIN_W-1:0] loop_gain_b = '0;
  logic gain_update_a = 1'b0;
  logic gain_update_b = 1'b0;
  logic master_reset_n = 1'b1;
  logic converter_power_down = 1'b0;
  logic [SEL_W-1:0] sel_pins = '0;
  logic [SEL_W-1:0] slave_pins;
  logic [SEL_W-1:0] parallel_word_select;
  logic parallel_port_enable_n = 1'b1;
  logic slave_clock_in;
  serial_pins_s serial_out;
  logic serial_oe;
  logic [WORD_W-1:0] parallel_word_bus;
  logic parallel_oe;
  logic [GAIN_W-1:0] gain_code_a;
  logic [GAIN_W-1:0] gain_code_b;
  logic gain_latch_a_n;
  logic gain_latch_b_n;
  logic adc_power_down;
  logic cfg_clk_pol = 1'b0;
  logic cfg_frame_pol = 1'b0;
  logic daisy_on = 1'b0;
  logic [PAIR_W-1:0] rx_a;
  logic [PAIR_W-1:0] rx_b;
  logic [1:0] rx_frames;
  logic [15:0] rx_count;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  assign parallel_word_select = daisy_on ? slave_pins : sel_pins;
  always #10 clk_sys = ~clk_sys;
  ddc_output_ports ddc_output_ports_inst (.clk_sys(clk_sys), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_a(sample_a),
    .sample_b(sample_b), .word_bank(word_bank), .debug_word(debug_word),
    .loop_gain_a(loop_gain_a), .loop_gain_b(loop_gain_b), .gain_update_a(gain_update_a),
    .gain_update_b(gain_update_b), .master_reset_n(master_reset_n),
    .converter_power_down(converter_power_down), .parallel_word_select(parallel_word_select),
    .parallel_port_enable_n(parallel_port_enable_n), .slave_clock_in(slave_clock_in),
    .serial_out(serial_out), .serial_oe(serial_oe), .parallel_word_bus(parallel_word_bus),
    .parallel_oe(parallel_oe), .gain_code_a(gain_code_a), .gain_code_b(gain_code_b),
    .gain_latch_a_n(gain_latch_a_n), .gain_latch_b_n(gain_latch_b_n),
    .adc_power_down(adc_power_down));
  ddc_link_partner ddc_link_partner_inst (.clk_sys(clk_sys), .nrst(nrst),
    .serial_out(serial_out), .serial_oe(serial_oe), .clk_pol(cfg_clk_pol),
    .frame_pol(cfg_frame_pol), .rx_a(rx_a), .rx_b(rx_b), .rx_frames(rx_frames),
    .rx_count(rx_count), .slave_clock_in(slave_clock_in), .slave_pins(slave_pins));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic t_regs;
    logic [31:0] d;
    reg_write(8'h20, 32'hFFFFFFFF);
    reg_read(ADDR_CTRL, d);
    check(d, 32'(CTRL_RESET), "ctrl reset");
    reg_read(ADDR_RATE, d);
    check(d, 32'(RATE_RESET), "rate reset");
    reg_read(8'h20, d);
    check(d, 32'h0, "unmapped");
    check({30'h0, serial_oe, parallel_oe}, 32'h0, "oe after reset");
    check({30'h0, gain_latch_a_n, gain_latch_b_n}, 32'h3, "latch idle");
  endtask : t_regs
  task automatic t_gain;
    int n;
    @(posedge clk_sys);
    loop_gain_a <= 3'h5;
    loop_gain_b <= 3'h2;
    gain_update_a <= 1'b1;
    gain_update_b <= 1'b1;
    @(posedge clk_sys);
    gain_update_a <= 1'b0;
    gain_update_b <= 1'b0;
    for (n = 0; n < 4; n++)
    begin
      #1;
      check({26'h0, gain_code_a, gain_code_b}, 32'h2A, "gain code");
      check({30'h0, gain_latch_a_n, gain_latch_b_n},
            (n < GAIN_STROBE_CYCLES) ? 32'h0 : 32'h3, "gain latch");
      @(posedge clk_sys);
    end
  endtask : t_gain
  task automatic t_pd;
    int n;
    for (n = 1; n >= 0; n--)
    begin
      @(posedge clk_sys);
      converter_power_down <= n[0];
      settle(5);
      check(32'(adc_power_down), 32'(n), "power down");
    end
  endtask : t_pd
  task automatic t_par;
    int k;
    settle(5);
    check(32'(parallel_oe), 32'h0, "par off");
    for (k = 0; k < NUM_WORDS; k++)
    begin
      @(posedge clk_sys);
      sel_pins <= 3'(k);
      parallel_port_enable_n <= 1'b0;
      settle(5);
      check(32'(parallel_word_bus), 32'(word_bank[k]), "par word");
      check(32'(parallel_oe), 32'h1, "par on");
    end
    @(posedge clk_sys);
    parallel_port_enable_n <= 1'b1;
  endtask : t_par
  task automatic t_serial;
    logic [3:0] cfg [3];
    logic [31:0] ra;
    logic [31:0] rb;
    int n;
    int t;
    logic [15:0] s;
    cfg = '{4'b1000, 4'b0101, 4'b1110};
    @(posedge clk_sys);
    sample_a <= {16'h8123, 16'h7F0E};
    sample_b <= {16'hC35A, 16'h00F1};
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    for (n = 0; n < 3; n++)
    begin
      cfg_frame_pol <= cfg[n][2];
      cfg_clk_pol <= cfg[n][1];
      reg_write(ADDR_RATE, {31'h0, cfg[n][0]});
      reg_write(ADDR_CTRL, {28'h0, cfg[n][2], cfg[n][3], cfg[n][1], 1'b1});
      s = rx_count;
      for (t = 0; t < 2000 && rx_count < s + 16'h3; t++)
        @(posedge clk_sys);
      #1;
      ra = rx_a;
      rb = rx_b;
      if (!cfg[n][3] && ra[31:16] === sample_a.q)
      begin
        ra = {ra[15:0], ra[31:16]};
        rb = {rb[15:0], rb[31:16]};
      end
      check(32'(serial_oe), 32'h1, "serial on");
      check(32'(rx_count - s), 32'h3, "pairs received");
      check(ra, sample_a, "serial a");
      check(rb, sample_b, "serial b");
      check(32'(rx_frames), cfg[n][3] ? 32'h1 : 32'h2, "frames");
    end
  endtask : t_serial
  task automatic t_debug;
    logic [19:0] dv [2];
    int n;
    dv = '{20'h9A5C6, 20'h65A39};
    reg_write(ADDR_CTRL, 32'h10);
    for (n = 0; n < 2; n++)
    begin
      @(posedge clk_sys);
      debug_word <= dv[n];
      sel_pins <= 3'(n + 3);
      settle(6);
      check(32'(parallel_word_bus), 32'(dv[n][19:4]), "debug par");
      check({29'h0, serial_out.serial_data_a, serial_out.serial_data_b,
             serial_out.serial_frame_strobe}, {29'h0, dv[n][1], dv[n][0], dv[n][2]},
            "debug serial");
      check({30'h0, parallel_oe, serial_oe}, 32'h3, "debug oe");
    end
  endtask : t_debug
  task automatic t_daisy;
    logic [31:0] d;
    reg_write(ADDR_CTRL, 32'h20);
    daisy_on <= 1'b1;
    ddc_link_partner_inst.send_slave(32'h87654321, 32'h0F1E2D3C);
    settle(8);
    reg_read(ADDR_SLAVE_A, d);
    check(d, 32'h87654321, "slave a");
    reg_read(ADDR_SLAVE_B, d);
    check(d, 32'h0F1E2D3C, "slave b");
    reg_read(ADDR_STATUS, d);
    check(32'(d[31:16]), 32'h1, "slave count");
    daisy_on <= 1'b0;
  endtask : t_daisy
  task automatic t_mreset;
    logic [31:0] d;
    reg_write(ADDR_CTRL, 32'h1);
    settle(3);
    check(32'(serial_oe), 32'h1, "enabled");
    @(posedge clk_sys);
    master_reset_n <= 1'b0;
    settle(5);
    check({29'h0, gain_latch_a_n, gain_latch_b_n, serial_oe}, 32'h0, "mreset");
    reg_write(ADDR_CTRL, 32'h1);
    @(posedge clk_sys);
    master_reset_n <= 1'b1;
    settle(5);
    reg_read(ADDR_CTRL, d);
    check(d, 32'h0, "ctrl cleared");
    reg_read(ADDR_STATUS, d);
    check(32'(d[31:16]), 32'h0, "count cleared");
  endtask : t_mreset
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      test_done();
    end
  end
  initial
  begin
    for (int k = 0; k < NUM_WORDS; k++)
      word_bank[k] = 16'h8421 ^ (16'h1357 * 16'(k));
    settle(10);
    check({30'h0, gain_latch_a_n, gain_latch_b_n}, 32'h0, "latch in reset");
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    settle(4);
    t_regs();
    t_gain();
    t_pd();
    t_par();
    t_serial();
    t_debug();
    t_daisy();
    t_mreset();
    test_done();
  end
endmodule : ddc_output_ports_test
